// ==== src/ssd_pkg.sv ====
/*
 * shared constants of the synthesizer serial setup link: word layout,
 * field positions, timing and host register map.
 * assumes a 100 MHz system clock on both ends.
 */
package ssd_pkg;
    localparam int WORD_BITS = 24;
    // field positions, counted from zero (printed bit n sits at n-1)
    localparam int POS_SELECT = 0;
    localparam int POS_SECONDARY = 23;
    localparam int POS_REF_LO = 1;
    localparam int POS_REF_HI = 11;
    localparam int POS_RELOAD = 12;
    localparam int POS_PUMP_OFF = 13;
    localparam int POS_BAND2_LO = 14;
    localparam int POS_SLOPE = 16;
    localparam int POS_BAND1_LO = 17;
    localparam int POS_INIT = 19;
    localparam int POS_EXT_RES = 20;
    localparam int POS_ENABLE = 21;
    localparam int POS_LOCK_EN = 22;
    localparam int POS_SWALLOW_LO = 1;
    localparam int POS_SWALLOW_HI = 7;
    localparam int POS_COARSE_LO = 8;
    localparam int POS_COARSE_HI = 18;
    localparam int POS_BAND_SEL = 22;
    localparam int RATIO_W = 11;
    localparam int SWALLOW_W = 7;
    localparam logic [RATIO_W-1:0] RATIO_MIN = 11'h002;
    // values after reset
    localparam logic [RATIO_W-1:0] RST_RATIO = 11'h7FF;
    localparam logic [SWALLOW_W-1:0] RST_SWALLOW = 7'h00;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 50;
    localparam int LOAD_WIDTH_NS = 50;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_WIDTH_CYC = (LOAD_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_WINDOW_CYC = 4;
    // host register map (byte addresses)
    localparam logic [3:0] ADDR_WORD = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_LOW = 2'b01,
        HS_HIGH = 2'b10,
        HS_LOAD = 2'b11
    } ssd_host_state_t;
endpackage : ssd_pkg

// ==== src/ssd_link_if.sv ====
/*
 * three-wire serial link between host controller and synthesizer.
 * assumes both ends run on their own clocks; the link is plain wires.
 */
`timescale 1ns/1ps
interface ssd_link_if;
    logic serialClk;
    logic serialData;
    logic load_strobe;
    modport device (input serialClk, input serialData, input load_strobe);
    modport host (output serialClk, output serialData, output load_strobe);
endinterface : ssd_link_if

// ==== src/ssd_sync3.sv ====
/*
 * three flip-flop input synchroniser with agreement filter.
 * assumes an asynchronous input; output follows once stages two and three agree.
 */
`timescale 1ns/1ps
module ssd_sync3 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            dout <= (s2_reg == s3_reg) ? s3_reg : dout;
        end
    end
endmodule : ssd_sync3

// ==== src/ssd_device.sv ====
/*
 * synthesizer end: serial front end, divider-setup and channel registers,
 * reference and main dividers, phase detector and lock indicator.
 * assumes link pins, reference and prescaled vco inputs come from other domains.
 */
`timescale 1ns/1ps
module ssd_device import ssd_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    ssd_link_if.device link,
    input wire logic refIn,
    input wire logic vcoIn,
    input wire logic powerdown_pin,
    output logic modulusHigh,
    output logic pumpUp,
    output logic pumpDown,
    output logic pumpOe,
    output logic [1:0] pumpCode,
    output logic extResSel,
    output logic running,
    output logic lock_output_pin
);
    logic clkS;
    logic datS;
    logic loadS;
    logic refS;
    logic vcoS;
    logic pinS;
    logic clkD_reg;
    logic loadD_reg;
    logic refD_reg;
    logic vcoD_reg;
    logic [WORD_BITS-1:0] shift_reg;
    logic [RATIO_W-1:0] refRatio_reg;
    logic forcedReload_reg;
    logic pumpOff_reg;
    logic [1:0] band2Code_reg;
    logic detectorSlope_reg;
    logic [1:0] band1Code_reg;
    logic extRes_reg;
    logic enable_reg;
    logic lockEn_reg;
    logic [SWALLOW_W-1:0] swallow_reg;
    logic [RATIO_W-1:0] coarse_reg;
    logic bandSel_reg;
    logic [RATIO_W-1:0] refCnt_reg;
    logic [RATIO_W-1:0] mainCnt_reg;
    logic [SWALLOW_W-1:0] swCnt_reg;
    logic upOut_reg;
    logic downOut_reg;
    logic [2:0] errCnt_reg;
    logic unlocked_reg;

    ssd_sync3 syncClk (.mclk(mclk), .rst(rst), .din(link.serialClk), .dout(clkS));
    ssd_sync3 syncDat (.mclk(mclk), .rst(rst), .din(link.serialData), .dout(datS));
    ssd_sync3 syncLoad (.mclk(mclk), .rst(rst), .din(link.load_strobe), .dout(loadS));
    ssd_sync3 syncRef (.mclk(mclk), .rst(rst), .din(refIn), .dout(refS));
    ssd_sync3 syncVco (.mclk(mclk), .rst(rst), .din(vcoIn), .dout(vcoS));
    ssd_sync3 syncPin (.mclk(mclk), .rst(rst), .din(powerdown_pin), .dout(pinS));

    wire shiftEn = clkS & ~clkD_reg;
    wire loadEv = loadS & ~loadD_reg & ~clkS;
    wire forUs = loadEv & ~shift_reg[POS_SECONDARY];
    wire setupWr = forUs & shift_reg[POS_SELECT];
    wire chanWr = forUs & ~shift_reg[POS_SELECT];
    wire initWr = setupWr & shift_reg[POS_INIT];
    // forced reload follows the new setting on a setup write
    wire forceNow = (setupWr & shift_reg[POS_RELOAD]) | (chanWr & forcedReload_reg);
    wire refEdge = refS & ~refD_reg & running;
    wire vcoEdge = vcoS & ~vcoD_reg & running;
    wire refEnd = refEdge & (refCnt_reg <= 11'h001);
    wire mainEnd = vcoEdge & (mainCnt_reg <= 11'h001);
    wire [RATIO_W-1:0] newRatio = shift_reg[POS_REF_HI:POS_REF_LO];
    wire [SWALLOW_W-1:0] newSwallow = shift_reg[POS_SWALLOW_HI:POS_SWALLOW_LO];
    wire [RATIO_W-1:0] newCoarse = shift_reg[POS_COARSE_HI:POS_COARSE_LO];
    wire [RATIO_W-1:0] ratioUse = (setupWr & ~initWr) ? newRatio : refRatio_reg;
    wire [RATIO_W-1:0] coarseUse = chanWr ? newCoarse : coarse_reg;
    wire [SWALLOW_W-1:0] swallowUse = chanWr ? newSwallow : swallow_reg;
    wire refLeads = detectorSlope_reg ? refEnd : mainEnd;
    wire mainLeads = detectorSlope_reg ? mainEnd : refEnd;

    // link pins are the only programming path
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clkD_reg <= 1'b0;
            loadD_reg <= 1'b0;
            refD_reg <= 1'b0;
            vcoD_reg <= 1'b0;
            shift_reg <= 24'h000000;
        end else begin
            clkD_reg <= clkS;
            loadD_reg <= loadS;
            refD_reg <= refS;
            vcoD_reg <= vcoS;
            // first bit ends at the top
            if (shiftEn) begin
                shift_reg <= {shift_reg[WORD_BITS-2:0], datS};
            end
        end
    end

    // all fields on the load edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refRatio_reg <= RST_RATIO;
            forcedReload_reg <= 1'b0;
            pumpOff_reg <= 1'b0;
            band2Code_reg <= 2'h0;
            detectorSlope_reg <= 1'b0;
            band1Code_reg <= 2'h0;
            extRes_reg <= 1'b0;
            lockEn_reg <= 1'b0;
        end else if (setupWr) begin
            // counter values kept on init reset
            refRatio_reg <= ratioUse;
            forcedReload_reg <= shift_reg[POS_RELOAD];
            pumpOff_reg <= shift_reg[POS_PUMP_OFF];
            band2Code_reg <= shift_reg[POS_BAND2_LO+1:POS_BAND2_LO];
            detectorSlope_reg <= shift_reg[POS_SLOPE];
            band1Code_reg <= shift_reg[POS_BAND1_LO+1:POS_BAND1_LO];
            extRes_reg <= shift_reg[POS_EXT_RES];
            lockEn_reg <= shift_reg[POS_LOCK_EN];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            swallow_reg <= RST_SWALLOW;
            coarse_reg <= RST_RATIO;
            bandSel_reg <= 1'b0;
            enable_reg <= 1'b0;
        end else begin
            if (chanWr) begin
                swallow_reg <= newSwallow;
                coarse_reg <= newCoarse;
                bandSel_reg <= shift_reg[POS_BAND_SEL];
            end
            if (initWr) begin
                enable_reg <= 1'b0;
            end else if (forUs) begin
                enable_reg <= shift_reg[POS_ENABLE];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refCnt_reg <= RST_RATIO;
        end else if (forceNow) begin
            refCnt_reg <= ratioUse;
        end else if (refEnd) begin
            refCnt_reg <= refRatio_reg;
        end else if (refEdge) begin
            refCnt_reg <= refCnt_reg - 11'h001;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mainCnt_reg <= RST_RATIO;
            swCnt_reg <= RST_SWALLOW;
        end else if (forceNow) begin
            mainCnt_reg <= coarseUse;
            swCnt_reg <= swallowUse;
        end else if (mainEnd) begin
            mainCnt_reg <= coarse_reg;
            swCnt_reg <= swallow_reg;
        end else if (vcoEdge) begin
            mainCnt_reg <= mainCnt_reg - 11'h001;
            swCnt_reg <= (swCnt_reg != 7'h00) ? swCnt_reg - 7'h01 : swCnt_reg;
        end
    end

    // phase detector and lock window
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            upOut_reg <= 1'b0;
            downOut_reg <= 1'b0;
            errCnt_reg <= 3'h0;
            unlocked_reg <= 1'b0;
        end else begin
            if ((upOut_reg | refLeads) & (downOut_reg | mainLeads)) begin
                upOut_reg <= 1'b0;
                downOut_reg <= 1'b0;
            end else begin
                upOut_reg <= upOut_reg | refLeads;
                downOut_reg <= downOut_reg | mainLeads;
            end
            if (upOut_reg | downOut_reg) begin
                errCnt_reg <= (errCnt_reg == 3'h7) ? errCnt_reg : errCnt_reg + 3'h1;
            end else begin
                errCnt_reg <= 3'h0;
            end
            if (errCnt_reg >= 3'(LOCK_WINDOW_CYC)) begin
                unlocked_reg <= 1'b1;
            end else if (refEnd & ~upOut_reg & ~downOut_reg) begin
                unlocked_reg <= 1'b0;
            end
        end
    end

    assign running = pinS & enable_reg;
    assign modulusHigh = swCnt_reg != 7'h00;
    assign pumpUp = upOut_reg;
    assign pumpDown = downOut_reg;
    assign pumpOe = running & ~pumpOff_reg;
    // band chooses code; code carried to the current dac
    assign pumpCode = bandSel_reg ? band2Code_reg : band1Code_reg;
    assign extResSel = extRes_reg;
    assign lock_output_pin = ~(lockEn_reg & unlocked_reg);
endmodule : ssd_device

// ==== src/ssd_host.sv ====
/*
 * host controller end: axi4-lite slave taking 24-bit words and sending
 * them over the three-wire link with a divided serial clock.
 * assumes software polls status; one word in flight at a time.
 */
`timescale 1ns/1ps
module ssd_host import ssd_pkg::*; #(
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter int LOAD_CYC = LOAD_WIDTH_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    ssd_link_if.host link,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    if (HALF_CYC < SCLK_HALF_CYC || LOAD_CYC < LOAD_WIDTH_CYC || HALF_CYC > 255
            || LOAD_CYC > 255) begin : gTimingCheck
        $error("ssd_host: timing parameters out of range");
    end

    ssd_host_state_t state_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [3:0] addr_reg;
    logic [31:0] data_reg;
    logic [WORD_BITS-1:0] word_reg;
    logic [4:0] bitCnt_reg;
    logic [7:0] tick_reg;
    logic initDone_reg;
    logic refused_reg;
    logic sclk_reg;
    logic sdat_reg;
    logic sload_reg;

    wire busy = state_reg != HS_IDLE;
    wire doWrite = awHeld_reg & wHeld_reg & ~bvalid;
    wire hitWord = addr_reg == ADDR_WORD;
    wire [WORD_BITS-1:0] w = data_reg[WORD_BITS-1:0];
    wire isSetup = ~w[POS_SECONDARY] & w[POS_SELECT];
    wire isChan = ~w[POS_SECONDARY] & ~w[POS_SELECT];
    wire badRatio = isSetup & (w[POS_REF_HI:POS_REF_LO] < RATIO_MIN);
    // swallow below coarse, coarse at least 2
    wire badChan = isChan & ((w[POS_COARSE_HI:POS_COARSE_LO] < RATIO_MIN)
        | ({4'h0, w[POS_SWALLOW_HI:POS_SWALLOW_LO]} >= w[POS_COARSE_HI:POS_COARSE_LO]));
    // first setup word must carry init
    wire badInit = isSetup & ~initDone_reg & ~w[POS_INIT];
    wire reject = busy | badRatio | badChan | badInit | (wstrb[2:0] != 3'h7);
    wire start = doWrite & hitWord & ~reject;
    wire tickDone = tick_reg == 8'h00;

    assign awready = ~awHeld_reg & ~bvalid;
    assign wready = ~wHeld_reg & ~bvalid;
    assign arready = ~rvalid;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            addr_reg <= 4'h0;
            data_reg <= 32'h00000000;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            refused_reg <= 1'b0;
        end else begin
            if (awvalid & awready) begin
                awHeld_reg <= 1'b1;
                addr_reg <= awaddr;
            end
            if (wvalid & wready) begin
                wHeld_reg <= 1'b1;
                data_reg <= wdata;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (hitWord & ~reject) ? 2'h0 : 2'h2;
                refused_reg <= hitWord & reject;
            end else if (bvalid & bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else if (arvalid & arready) begin
            rvalid <= 1'b1;
            rdata <= (araddr == ADDR_STATUS) ? {29'h0, refused_reg, initDone_reg, busy}
                : 32'h00000000;
            rresp <= (araddr == ADDR_STATUS) ? 2'h0 : 2'h2;
        end else if (rvalid & rready) begin
            rvalid <= 1'b0;
        end
    end

    // serial engine, bit 24 first, load with clock low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= HS_IDLE;
            word_reg <= 24'h000000;
            bitCnt_reg <= 5'h00;
            tick_reg <= 8'h00;
            initDone_reg <= 1'b0;
            sclk_reg <= 1'b0;
            sdat_reg <= 1'b0;
            sload_reg <= 1'b0;
        end else begin
            tick_reg <= tickDone ? tick_reg : tick_reg - 8'h01;
            case (state_reg)
                HS_IDLE: begin
                    if (start) begin
                        word_reg <= {w[WORD_BITS-2:0], 1'b0};
                        sdat_reg <= w[WORD_BITS-1];
                        bitCnt_reg <= 5'(WORD_BITS - 1);
                        tick_reg <= 8'(HALF_CYC - 1);
                        initDone_reg <= initDone_reg | (isSetup & w[POS_INIT]);
                        state_reg <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (tickDone) begin
                        sclk_reg <= 1'b1;
                        tick_reg <= 8'(HALF_CYC - 1);
                        state_reg <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (tickDone) begin
                        sclk_reg <= 1'b0;
                        tick_reg <= 8'(HALF_CYC - 1);
                        if (bitCnt_reg == 5'h00) begin
                            sload_reg <= 1'b0;
                            state_reg <= HS_LOAD;
                        end else begin
                            sdat_reg <= word_reg[WORD_BITS-1];
                            word_reg <= {word_reg[WORD_BITS-2:0], 1'b0};
                            bitCnt_reg <= bitCnt_reg - 5'h01;
                            state_reg <= HS_LOW;
                        end
                    end
                end
                HS_LOAD: begin
                    if (tickDone & ~sload_reg) begin
                        sload_reg <= 1'b1;
                        tick_reg <= 8'(LOAD_CYC - 1);
                    end else if (tickDone) begin
                        sload_reg <= 1'b0;
                        state_reg <= HS_IDLE;
                    end
                end
                default: begin
                    state_reg <= HS_IDLE;
                end
            endcase
        end
    end

    assign link.serialClk = sclk_reg;
    assign link.serialData = sdat_reg;
    assign link.load_strobe = sload_reg;
endmodule : ssd_host

// ==== dv/ssd_link_asserts.sv ====
/*
 * link checker: timing and framing of the three-wire serial link.
 * assumes the host and device ends meet in one ssd_link_if on mclk.
 */
`timescale 1ns/1ps
module ssd_link_asserts #(
    parameter int HALF_CYC = 5,
    parameter int LOAD_CYC = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic load_strobe
);
    logic [7:0] hiCnt;
    logic [7:0] ldCnt;
    logic [5:0] riseCnt;
    wire clkRise = serialClk && (hiCnt == 8'h00);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hiCnt <= 8'h00;
            ldCnt <= 8'h00;
            riseCnt <= 6'h00;
        end else begin
            hiCnt <= serialClk ? hiCnt + 8'h01 : 8'h00;
            ldCnt <= load_strobe ? ldCnt + 8'h01 : 8'h00;
            riseCnt <= load_strobe ? 6'h00 : (clkRise ? riseCnt + 6'h01 : riseCnt);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    clk_high_width_a: assert property (
        $fell(serialClk) |-> hiCnt == 8'(HALF_CYC)) else $error("clock high width wrong");
    clk_low_width_a: assert property (
        $fell(serialClk) |-> !serialClk [*5]) else $error("clock low width wrong");
    data_stable_a: assert property (
        serialClk |-> $stable(serialData)) else $error("data moved while clock high");
    load_clock_low_a: assert property (
        load_strobe |-> !serialClk) else $error("load while clock high");
    load_width_a: assert property (
        $fell(load_strobe) |-> ldCnt == 8'(LOAD_CYC)) else $error("load width wrong");
    word_length_a: assert property (
        $rose(load_strobe) |-> riseCnt == 6'h18) else $error("word not 24 bits");
    load_after_last_a: assert property (
        $fell(serialClk) && riseCnt == 6'h18 |-> ##[1:8] $rose(load_strobe))
        else $error("no load after last bit");
    word_time_a: assert property (
        clkRise && riseCnt == 6'h00 |-> ##[200:300] $rose(load_strobe))
        else $error("word time out of range");
endmodule : ssd_link_asserts

// ==== dv/tb_synth_serial_divider_setup.sv ====
/*
 * bench: host and device joined by the link, driven over axi4-lite.
 * assumes default host timing and free running reference and vco inputs.
 */
`timescale 1ns/1ps
module tb_synth_serial_divider_setup import ssd_pkg::*;;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic refIn = 1'b0;
    logic vcoIn = 1'b0;
    logic powerdown_pin = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [3:0] araddr = 4'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, pumpCode;
    logic [31:0] rdata;
    logic pumpOe, extResSel, running, lockOut, modHigh;
    logic [31:0] s;
    logic [1:0] r;
    int failures = 0;
    int compares = 0;
    always #5 mclk = ~mclk;
    int divCnt = 0;
    always @(posedge mclk) begin
        divCnt <= divCnt + 1;
        if (divCnt % 8 == 7) refIn <= ~refIn;
        if (divCnt % 3 == 2) vcoIn <= ~vcoIn;
    end
    ssd_link_if link ();
    ssd_host #(.HALF_CYC(5), .LOAD_CYC(5)) u_ssd_host (.mclk(mclk), .rst(rst), .link(link),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    ssd_device u_ssd_device (.mclk(mclk), .rst(rst), .link(link), .refIn(refIn), .vcoIn(vcoIn),
        .powerdown_pin(powerdown_pin), .modulusHigh(modHigh), .pumpUp(), .pumpDown(),
        .pumpOe(pumpOe),
        .pumpCode(pumpCode), .extResSel(extResSel), .running(running),
        .lock_output_pin(lockOut));
    ssd_link_asserts #(.HALF_CYC(5), .LOAD_CYC(5)) u_ssd_link_asserts (.mclk(mclk), .rst(rst),
        .serialClk(link.serialClk), .serialData(link.serialData),
        .load_strobe(link.load_strobe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_read
    // send one word, check the response, wait until the link is idle
    task automatic send(input logic [31:0] w, input logic [1:0] er);
        logic [31:0] st;
        logic [1:0] rs;
        axi_write(ADDR_WORD, w, rs);
        check(32'(rs), 32'(er));
        do begin
            axi_read(ADDR_STATUS, st, rs);
            @(posedge mclk);
        end while (st[0] !== 1'b0);
        repeat (12) @(posedge mclk);
    endtask : send
    // d: {band1, slope, band2, pump off, reload}; f: {lock en, enable, ext res, init}
    function automatic logic [31:0] su(input logic [10:0] q, input logic [6:0] d,
        input logic [3:0] f);
        return {9'h000, f, d, q, 1'b1};
    endfunction : su
    function automatic logic [31:0] ch(input logic [10:0] m, input logic en, input logic b);
        return {8'h00, 1'b0, b, en, 2'b00, m, 7'h24, 1'b0};
    endfunction : ch
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check(32'(running), 32'h0);
        check(32'(lockOut), 32'h1);
        axi_read(4'h8, s, r);
        check(32'(r), 32'h2);
        send(su(11'h041, 7'h00, 4'h4), 2'h2);
        send(su(11'h001, 7'h00, 4'h5), 2'h2);
        send(su(11'h041, 7'h00, 4'h5), 2'h0);
        check(32'(running), 32'h0);
        $display("test init done");
        send(ch(11'h05B, 1'b1, 1'b0), 2'h0);
        for (int c = 0; c < 4; c++) begin
            send(su(11'h041, {2'(c), 5'h00}, 4'h6), 2'h0);
            check(32'(pumpCode), 32'(c));
            check(32'(running), 32'h1);
            check(32'(extResSel), 32'h1);
        end
        send(su(11'h041, 7'h28, 4'h6), 2'h0);
        send(ch(11'h05B, 1'b1, 1'b1), 2'h0);
        check(32'(pumpCode), 32'h2);
        check(32'(pumpOe), 32'h1);
        send(su(11'h041, 7'h2A, 4'h4), 2'h0);
        check(32'(pumpOe), 32'h0);
        check(32'(extResSel), 32'h0);
        $display("test pump done");
        send(32'h00E0_0001 | su(11'h041, 7'h00, 4'h6), 2'h0);
        check(32'(extResSel), 32'h0);
        check(32'(lockOut), 32'h1);
        send(su(11'h041, 7'h01, 4'h4), 2'h0);
        send(ch(11'h05B, 1'b0, 1'b1), 2'h0);
        check(32'(modHigh), 32'h1);
        send(ch(11'h05B, 1'b1, 1'b1), 2'h0);
        check(32'(running), 32'h1);
        send(ch(11'h05B, 1'b0, 1'b1), 2'h0);
        check(32'(running), 32'h0);
        send(ch(11'h05B, 1'b1, 1'b1), 2'h0);
        powerdown_pin <= 1'b0;
        repeat (10) @(posedge mclk);
        check(32'(running), 32'h0);
        $display("test enable done");
        print_verdict();
    end
    initial begin
        #500000;
        failures++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule : tb_synth_serial_divider_setup
